// ===== rtl/uesc_engine.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
// Operation
// - Six halt bits for endpoints 5..0 at bits 5..0; 1 means halted.
// - USB bus reset and power-on reset clear all six halt bits.
// - A SETUP token clears the endpoint 0 halt bit.
// - Halt register bits 7 and 6 read zero and ignore writes.
// - NAK interrupt only when global bit 7 set and endpoint mask bit set.
// - CRC, PID or incomplete token error sets bit 5 until firmware or a USB bus reset clears it.
// - Read-only bit 4 sets when a NAK answers an IN or OUT token.
// - Bit 3 shows whether the latest endpoint 0 token was IN.
// - Endpoint 0 FIFO access error sets bit 1; firmware clears it.
// - With update bit 0, an address write loads the active address at once.
// - With update bit 1, the address loads after host reads endpoint 0 IN data.
// - Address in bits 7..1, wake-up enable in bit 0, address resets to zero.
`include "uesc_map.svh"

module uesc_engine
  import uesc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sie_bus_reset,
  input wire logic sie_tok_valid,
  input wire uesc_tok_t sie_tok_pid,
  input wire uesc_ep_t sie_tok_ep,
  input wire logic sie_out_nonzero,
  input wire logic sie_crc_err,
  input wire logic sie_pid_err,
  input wire logic sie_tok_incomplete,
  input wire logic sie_nak_sent,
  input wire uesc_ep_t sie_nak_ep,
  input wire logic sie_ep0_fifo_err,
  input wire logic sie_in_acked,
  output logic stall_reply,
  output logic [5:0] ep_halted,
  output logic [6:0] active_addr,
  output logic remote_wake_en,
  output logic nak_irq
);

  localparam int NEP = `UESC_NUM_EP;

  logic [NEP-1:0] halt_ff;
  logic [NEP-1:0] nak_mask_ff;
  logic nak_glb_ff;
  logic defer_ff;
  logic xfer_err_ff;
  logic nak_sent_ff;
  logic ep0_in_ff;
  logic ep0_out_ff;
  logic fifo_err_ff;
  logic [6:0] stored_addr_ff;
  logic wake_en_ff;
  logic addr_pending_ff;
  logic [6:0] active_addr_ff;
  logic nak_irq_ff;
  logic [31:0] prdata_ff;

  logic acc;
  logic wr_acc;
  logic rd_setup;
  logic rd_acc;
  logic mapped;
  logic wr_halt;
  logic wr_stat;
  logic wr_addr;
  logic wr_nmask;
  logic rd_stat;
  logic tok_ep0;
  logic setup_ep0;
  logic tok_ep_ok;
  logic nak_ep_ok;
  logic [31:0] rd_mux;

  // Bus phase decode
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `UESC_OFF_HALT: mapped = 1'b1;
      `UESC_OFF_STAT: mapped = 1'b1;
      `UESC_OFF_ADDR: mapped = 1'b1;
      `UESC_OFF_NMASK: mapped = 1'b1;
      `UESC_OFF_ACTADR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign wr_halt = wr_acc && (paddr == `UESC_OFF_HALT);
  assign wr_stat = wr_acc && (paddr == `UESC_OFF_STAT);
  assign wr_addr = wr_acc && (paddr == `UESC_OFF_ADDR);
  assign wr_nmask = wr_acc && (paddr == `UESC_OFF_NMASK);
  assign rd_stat = rd_acc && (paddr == `UESC_OFF_STAT);

  // Zero wait states; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_ff;

  // Token decode
  assign tok_ep_ok = (sie_tok_ep < uesc_ep_t'(NEP));
  assign nak_ep_ok = (sie_nak_ep < uesc_ep_t'(NEP));
  assign tok_ep0 = sie_tok_valid && (sie_tok_ep == uesc_ep_t'(0));
  assign setup_ep0 = tok_ep0 && (sie_tok_pid == UESC_TOK_SETUP);

  // Halt bits, firmware written, cleared by bus reset
  generate
    for (genvar i = 0; i < NEP; i++) begin : g_halt
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          halt_ff[i] <= 1'b0;
        end else if (sie_bus_reset) begin
          halt_ff[i] <= 1'b0;
        end else if ((i == 0) && setup_ep0) begin
          halt_ff[i] <= 1'b0;
        end else if (wr_halt) begin
          halt_ff[i] <= pwdata[i];
        end
      end
    end
  endgenerate

  assign ep_halted = halt_ff;

  // STALL answer for halted endpoints; SETUP is never stalled
  always_comb begin
    stall_reply = 1'b0;
    if (sie_tok_valid && tok_ep_ok && (sie_tok_pid != UESC_TOK_SETUP)) begin
      stall_reply = halt_ff[sie_tok_ep];
    end
  end

  // Control bits of the status register and the NAK mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_glb_ff <= 1'b0;
      defer_ff <= 1'b0;
    end else if (wr_stat) begin
      nak_glb_ff <= pwdata[`UESC_BIT_NAKGLB];
      defer_ff <= pwdata[`UESC_BIT_DEFER];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_mask_ff <= `UESC_NMASK_RST;
    end else if (wr_nmask) begin
      nak_mask_ff <= pwdata[NEP-1:0];
    end
  end

  // Transfer error: hardware set wins, firmware may only write 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_err_ff <= 1'b0;
    end else if (sie_crc_err || sie_pid_err || sie_tok_incomplete) begin
      xfer_err_ff <= 1'b1;
    end else if (sie_bus_reset) begin
      xfer_err_ff <= 1'b0;
    end else if (wr_stat && !pwdata[`UESC_BIT_XFERERR]) begin
      xfer_err_ff <= 1'b0;
    end
  end

  // NAK sent: read-only, cleared by a status read that saw it set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_sent_ff <= 1'b0;
    end else if (sie_nak_sent) begin
      nak_sent_ff <= 1'b1;
    end else if (sie_bus_reset) begin
      nak_sent_ff <= 1'b0;
    end else if (rd_stat && prdata_ff[`UESC_BIT_NAKSENT]) begin
      nak_sent_ff <= 1'b0;
    end
  end

  // Endpoint 0 IN token indication follows each endpoint 0 token
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep0_in_ff <= 1'b0;
    end else if (tok_ep0) begin
      ep0_in_ff <= (sie_tok_pid == UESC_TOK_IN);
    end else if (sie_bus_reset) begin
      ep0_in_ff <= 1'b0;
    end
  end

  // Endpoint 0 OUT data waiting; zero length OUT does not set it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep0_out_ff <= 1'b0;
    end else if (tok_ep0 && (sie_tok_pid == UESC_TOK_OUT) && sie_out_nonzero) begin
      ep0_out_ff <= 1'b1;
    end else if (sie_bus_reset) begin
      ep0_out_ff <= 1'b0;
    end else if (wr_stat && !pwdata[`UESC_BIT_EP0OUT]) begin
      ep0_out_ff <= 1'b0;
    end
  end

  // Endpoint 0 FIFO access error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_err_ff <= 1'b0;
    end else if (sie_ep0_fifo_err) begin
      fifo_err_ff <= 1'b1;
    end else if (sie_bus_reset) begin
      fifo_err_ff <= 1'b0;
    end else if (wr_stat && !pwdata[`UESC_BIT_FIFOERR]) begin
      fifo_err_ff <= 1'b0;
    end
  end

  // Gated NAK interrupt pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_irq_ff <= 1'b0;
    end else begin
      nak_irq_ff <= sie_nak_sent && nak_glb_ff && nak_ep_ok && nak_mask_ff[sie_nak_ep];
    end
  end

  assign nak_irq = nak_irq_ff;

  // Address register as firmware wrote it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_addr_ff <= `UESC_ADDR_RST;
      wake_en_ff <= 1'b0;
    end else if (sie_bus_reset) begin
      stored_addr_ff <= `UESC_ADDR_RST;
      wake_en_ff <= 1'b0;
    end else if (wr_addr) begin
      stored_addr_ff <= pwdata[`UESC_ADDR_MSB:`UESC_ADDR_LSB];
      wake_en_ff <= pwdata[`UESC_BIT_WAKE];
    end
  end

  assign remote_wake_en = wake_en_ff;

  // Deferred load waits for the host to accept endpoint 0 IN data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_pending_ff <= 1'b0;
    end else if (sie_bus_reset) begin
      addr_pending_ff <= 1'b0;
    end else if (wr_addr) begin
      addr_pending_ff <= defer_ff;
    end else if (sie_in_acked) begin
      addr_pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_addr_ff <= `UESC_ADDR_RST;
    end else if (sie_bus_reset) begin
      active_addr_ff <= `UESC_ADDR_RST;
    end else if (wr_addr && !defer_ff) begin
      active_addr_ff <= pwdata[`UESC_ADDR_MSB:`UESC_ADDR_LSB];
    end else if (addr_pending_ff && sie_in_acked) begin
      active_addr_ff <= stored_addr_ff;
    end
  end

  assign active_addr = active_addr_ff;

  // Read data is captured in the setup phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `UESC_OFF_HALT: begin
        rd_mux[NEP-1:0] = halt_ff;
      end
      `UESC_OFF_STAT: begin
        rd_mux[`UESC_BIT_NAKGLB] = nak_glb_ff;
        rd_mux[`UESC_BIT_XFERERR] = xfer_err_ff;
        rd_mux[`UESC_BIT_NAKSENT] = nak_sent_ff;
        rd_mux[`UESC_BIT_EP0IN] = ep0_in_ff;
        rd_mux[`UESC_BIT_EP0OUT] = ep0_out_ff;
        rd_mux[`UESC_BIT_FIFOERR] = fifo_err_ff;
        rd_mux[`UESC_BIT_DEFER] = defer_ff;
      end
      `UESC_OFF_ADDR: begin
        rd_mux[`UESC_ADDR_MSB:`UESC_ADDR_LSB] = stored_addr_ff;
        rd_mux[`UESC_BIT_WAKE] = wake_en_ff;
      end
      `UESC_OFF_NMASK: begin
        rd_mux[NEP-1:0] = nak_mask_ff;
      end
      `UESC_OFF_ACTADR: begin
        rd_mux[6:0] = active_addr_ff;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= rd_mux;
    end
  end

endmodule

// ===== shared/uesc_map.svh
`ifndef UESC_MAP_SVH
`define UESC_MAP_SVH

// Register byte offsets on the APB
`define UESC_OFF_HALT 12'h000
`define UESC_OFF_STAT 12'h004
`define UESC_OFF_ADDR 12'h008
`define UESC_OFF_NMASK 12'h00C
`define UESC_OFF_ACTADR 12'h010

// Endpoint count
`define UESC_NUM_EP 6

// Status and control field positions
`define UESC_BIT_NAKGLB 7
`define UESC_BIT_XFERERR 5
`define UESC_BIT_NAKSENT 4
`define UESC_BIT_EP0IN 3
`define UESC_BIT_EP0OUT 2
`define UESC_BIT_FIFOERR 1
`define UESC_BIT_DEFER 0

// Address register field positions
`define UESC_ADDR_MSB 7
`define UESC_ADDR_LSB 1
`define UESC_BIT_WAKE 0

// Reset values
`define UESC_HALT_RST 6'h00
`define UESC_NMASK_RST 6'h00
`define UESC_ADDR_RST 7'h00

`endif

// ===== shared/uesc_pkg.sv
package uesc_pkg;

  typedef enum logic [1:0] {
    UESC_TOK_OUT,
    UESC_TOK_IN,
    UESC_TOK_SETUP
  } uesc_tok_t;

  typedef logic [2:0] uesc_ep_t;

endpackage

// ===== verification/uesc_engine_tb.sv
`timescale 1ns/100ps
`include "uesc_map.svh"
module uesc_engine_tb
  import uesc_pkg::*;
;
  localparam logic [7:0] BRST = 8'h01, TOK = 8'h02, NAK = 8'h20, INACK = 8'h80;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic pready, pslverr, err_v, stall_reply, remote_wake_en, nak_irq, stall_seen;
  logic [7:0] ev;
  logic [7:0] errs [4] = '{8'h04, 8'h08, 8'h10, 8'h40};
  logic [31:0] err_bit [4] = '{32'h20, 32'h20, 32'h20, 32'h02};
  uesc_tok_t sie_tok_pid;
  uesc_ep_t sie_tok_ep, sie_nak_ep;
  logic sie_out_nonzero;
  logic [5:0] ep_halted;
  logic [6:0] active_addr;
  int bad_count = 0, checks_done = 0, irq_n = 0, n0;
  always #2.5 pclk = ~pclk;
  uesc_host hm (.pclk, .ev, .sie_tok_pid, .sie_tok_ep, .sie_nak_ep, .sie_out_nonzero);
  uesc_engine dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sie_bus_reset(ev[0]), .sie_tok_valid(ev[1]), .sie_tok_pid,
    .sie_tok_ep, .sie_out_nonzero, .sie_crc_err(ev[2]), .sie_pid_err(ev[3]),
    .sie_tok_incomplete(ev[4]), .sie_nak_sent(ev[5]), .sie_nak_ep,
    .sie_ep0_fifo_err(ev[6]), .sie_in_acked(ev[7]), .stall_reply, .ep_halted,
    .active_addr, .remote_wake_en, .nak_irq);
  always @(posedge pclk) begin
    if (ev[1]) stall_seen <= stall_reply;
    if (nak_irq === 1'b1) irq_n <= irq_n + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`UESC_OFF_HALT, 32'h0);
    rchk(`UESC_OFF_STAT, 32'h0);
    rchk(`UESC_OFF_ADDR, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk(err_v, 32'h1);
    $display("test reset done");
    apb(1'b1, `UESC_OFF_HALT, 32'h0000_00ff);
    rchk(`UESC_OFF_HALT, 32'h3f);
    hm.fire(TOK, UESC_TOK_IN, 3'h3, 1'b0);
    chk(stall_seen, 32'h1);
    hm.fire(TOK, UESC_TOK_SETUP, 3'h0, 1'b0);
    chk(stall_seen, 32'h0);
    rchk(`UESC_OFF_HALT, 32'h3e);
    chk(ep_halted, 32'h3e);
    hm.fire(BRST, UESC_TOK_OUT, 3'h0, 1'b0);
    rchk(`UESC_OFF_HALT, 32'h0);
    $display("test halt done");
    foreach (errs[i]) begin
      hm.fire(errs[i], UESC_TOK_OUT, 3'h1, 1'b0);
      rchk(`UESC_OFF_STAT, err_bit[i]);
      rchk(`UESC_OFF_STAT, err_bit[i]);
      apb(1'b1, `UESC_OFF_STAT, 32'h0);
      rchk(`UESC_OFF_STAT, 32'h0);
    end
    $display("test errors done");
    hm.fire(TOK, UESC_TOK_IN, 3'h0, 1'b0);
    rchk(`UESC_OFF_STAT, 32'h08);
    hm.fire(TOK, UESC_TOK_OUT, 3'h0, 1'b1);
    rchk(`UESC_OFF_STAT, 32'h04);
    apb(1'b1, `UESC_OFF_STAT, 32'h0);
    hm.fire(TOK, UESC_TOK_OUT, 3'h0, 1'b0);
    rchk(`UESC_OFF_STAT, 32'h0);
    $display("test tokens done");
    apb(1'b1, `UESC_OFF_NMASK, 32'h04);
    rchk(`UESC_OFF_NMASK, 32'h04);
    n0 = irq_n;
    hm.fire(NAK, UESC_TOK_OUT, 3'h2, 1'b0);
    rchk(`UESC_OFF_STAT, 32'h10);
    rchk(`UESC_OFF_STAT, 32'h0);
    apb(1'b1, `UESC_OFF_STAT, 32'h80);
    hm.fire(NAK, UESC_TOK_OUT, 3'h2, 1'b0);
    hm.fire(NAK, UESC_TOK_OUT, 3'h3, 1'b0);
    rchk(`UESC_OFF_STAT, 32'h90);
    chk(irq_n - n0, 32'h1);
    $display("test nak done");
    apb(1'b1, `UESC_OFF_STAT, 32'h0);
    apb(1'b1, `UESC_OFF_ADDR, 32'h55);
    rchk(`UESC_OFF_ACTADR, 32'h2a);
    chk(remote_wake_en, 32'h1);
    apb(1'b1, `UESC_OFF_STAT, 32'h01);
    apb(1'b1, `UESC_OFF_ADDR, 32'h0a);
    rchk(`UESC_OFF_ACTADR, 32'h2a);
    hm.fire(INACK, UESC_TOK_OUT, 3'h0, 1'b0);
    rchk(`UESC_OFF_ACTADR, 32'h05);
    chk(active_addr, 32'h05);
    chk(remote_wake_en, 32'h0);
    $display("test address done");
    report_and_stop;
  end
endmodule

// ===== verification/uesc_host.sv
`timescale 1ns/100ps
module uesc_host
  import uesc_pkg::*;
(
  input wire logic pclk,
  output logic [7:0] ev,
  output uesc_tok_t sie_tok_pid,
  output uesc_ep_t sie_tok_ep,
  output uesc_ep_t sie_nak_ep,
  output logic sie_out_nonzero
);
  initial begin
    ev = 8'h0;
    sie_tok_pid = UESC_TOK_OUT;
    sie_tok_ep = 3'h0;
    sie_nak_ep = 3'h0;
    sie_out_nonzero = 1'b0;
  end
  // One cycle pulse per event; idle endpoint and length lines carry the inverse so stale values never match
  task automatic fire(input logic [7:0] m, input uesc_tok_t p, input uesc_ep_t e,
                      input logic nz);
    @(posedge pclk);
    ev <= m;
    sie_tok_pid <= p;
    sie_tok_ep <= e;
    sie_nak_ep <= e;
    sie_out_nonzero <= nz;
    @(posedge pclk);
    ev <= 8'h0;
    sie_tok_ep <= ~e;
    sie_nak_ep <= ~e;
    sie_out_nonzero <= ~nz;
    #1;
  endtask
endmodule

// ===== verification/uesc_props.sv
`timescale 1ns/100ps
`include "uesc_map.svh"
module uesc_props
  import uesc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sie_bus_reset,
  input wire logic sie_tok_valid,
  input wire uesc_tok_t sie_tok_pid,
  input wire uesc_ep_t sie_tok_ep,
  input wire logic sie_nak_sent,
  input wire uesc_ep_t sie_nak_ep,
  input wire logic sie_in_acked,
  input wire logic stall_reply,
  input wire logic [5:0] ep_halted,
  input wire logic [6:0] active_addr,
  input wire logic remote_wake_en,
  input wire logic nak_irq
);
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  logic halt_wr;
  logic addr_src;
  logic wake_bit;
  assign halt_wr = wr_acc && paddr == `UESC_OFF_HALT;
  assign addr_src = (wr_acc && paddr == `UESC_OFF_ADDR) || sie_in_acked || sie_bus_reset;
  assign wake_bit = pwdata[`UESC_BIT_WAKE];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence addr_wr_s;
    wr_acc && paddr == `UESC_OFF_ADDR;
  endsequence
  stall_match_a:
    assert property (stall_reply == (sie_tok_valid && sie_tok_pid != UESC_TOK_SETUP
      && sie_tok_ep < 3'h6 && ep_halted[sie_tok_ep])) else $error("stall reply wrong");
  nak_cause_a:
    assert property (nak_irq |-> $past(sie_nak_sent) && $past(sie_nak_ep) < 3'h6)
      else $error("nak irq without cause");
  halt_sw_a:
    assert property ((ep_halted & ~$past(ep_halted)) != 6'h0 |-> $past(halt_wr))
      else $error("halt set by hardware");
  bus_clear_a:
    assert property (sie_bus_reset && !wr_acc |=> ep_halted == 6'h0 && active_addr == 7'h0)
      else $error("bus reset did not clear");
  setup_clear_a:
    assert property (sie_tok_valid && sie_tok_pid == UESC_TOK_SETUP && sie_tok_ep == 3'h0
      |=> !ep_halted[0]) else $error("setup did not clear halt");
  halt_upper_a:
    assert property (psel && penable && !pwrite && paddr == `UESC_OFF_HALT
      |-> prdata[31:6] == 26'h0) else $error("halt upper bits set");
  addr_cause_a:
    assert property ($changed(active_addr) |-> $past(addr_src))
      else $error("address changed alone");
  wake_load_a:
    assert property (addr_wr_s ##0 !sie_bus_reset |=> remote_wake_en == $past(wake_bit))
      else $error("wake enable not loaded");
  unmapped_err_a:
    assert property (psel && penable && (paddr > 12'h010 || paddr[1:0] != 2'h0)
      |-> pslverr) else $error("no error on unmapped");
endmodule
bind uesc_engine uesc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .sie_bus_reset, .sie_tok_valid, .sie_tok_pid, .sie_tok_ep,
  .sie_nak_sent, .sie_nak_ep, .sie_in_acked, .stall_reply, .ep_halted, .active_addr,
  .remote_wake_en, .nak_irq);
